// ===== rtl/tidec_defines.vh
//--------------------------------------------------------------
// What this block does
// - Open level stop contact holds drive stopped
// - Level run contact runs only while closed
// - Forward/reverse select levels set direction
// - Level run forward/reverse run, open stops
// - Keypad mode: enable starts or awaits key
// - Fieldbus start accepted only while enabled
// - Start pulse rising edge starts if stop closed
// - Paired start needs both active, stop closed
// - Stop contact falling edge stops the drive
// - Directional start pulses start that direction
// - Paired fast stop uses fast ramp
// - Fast stop contact falling edge, fast ramp
// - External trip on opening, code by format
// - Analog reference from input one or two
// - Single preset speed as reference
// - Two bits pick one of four presets
// - Keypad speed as reference
// - Fieldbus speed as reference
// - Analog feeds process loop, output is reference
// - Normally open closes, normally closed opens
// - Step speed up/down by first preset
//--------------------------------------------------------------
`ifndef TIDEC_DEFINES_VH
`define TIDEC_DEFINES_VH

// Register byte addresses
`define TIDEC_ADDR_CTRL 8'h00
`define TIDEC_ADDR_FUNC 8'h04
`define TIDEC_ADDR_PRE01 8'h08
`define TIDEC_ADDR_PRE23 8'h0C
`define TIDEC_ADDR_STATUS 8'h10
`define TIDEC_ADDR_SPEED 8'h14

// Control register fields
`define TIDEC_CTRL_MODE 1:0
`define TIDEC_CTRL_KPD_AUTO 2
`define TIDEC_CTRL_AI2_FMT 3
`define TIDEC_CTRL_TRIP_CLR 4
`define TIDEC_CTRL_BASE_SRC 7:5
`define TIDEC_CTRL_ALT_SRC 10:8
`define TIDEC_CTRL_PRESET 12:11
`define TIDEC_CTRL_FB_SEL 13
`define TIDEC_CTRL_RESET 32'h0000_0000
`define TIDEC_FUNC_RESET 32'h0000_0000

// Control modes
`define TIDEC_MODE_TERM 2'h0
`define TIDEC_MODE_KPD 2'h1
`define TIDEC_MODE_BUS 2'h2

// Terminal functions
`define TIDEC_FN_NONE 5'h00
`define TIDEC_FN_STOP_LVL 5'h01
`define TIDEC_FN_RUN_LVL 5'h02
`define TIDEC_FN_FWD_SEL 5'h03
`define TIDEC_FN_REV_SEL 5'h04
`define TIDEC_FN_RUN_FORWARD_LEVEL 5'h05
`define TIDEC_FN_RUN_REVERSE_LEVEL 5'h06
`define TIDEC_FN_START 5'h07
`define TIDEC_FN_START_PAIR 5'h08
`define TIDEC_FN_STOP_NC 5'h09
`define TIDEC_FN_START_FORWARD_PULSE 5'h0A
`define TIDEC_FN_START_REVERSE_PULSE 5'h0B
`define TIDEC_FN_FAST_PAIR 5'h0C
`define TIDEC_FN_FAST_NC 5'h0D
`define TIDEC_FN_TRIP_NC 5'h0E
`define TIDEC_FN_ALT_REF 5'h0F
`define TIDEC_FN_PRE_B0 5'h10
`define TIDEC_FN_PRE_B1 5'h11
`define TIDEC_FN_STEP_UP 5'h12
`define TIDEC_FN_STEP_DN 5'h13

// Speed sources
`define TIDEC_SRC_AI1 3'h0
`define TIDEC_SRC_AI2 3'h1
`define TIDEC_SRC_PRESET 3'h2
`define TIDEC_SRC_GROUP 3'h3
`define TIDEC_SRC_KPD 3'h4
`define TIDEC_SRC_BUS 3'h5
`define TIDEC_SRC_LOOP 3'h6
`define TIDEC_SRC_STEP 3'h7

// Timing
`define TIDEC_CLK_MHZ 50
`define TIDEC_DEBOUNCE_US 1000
`define TIDEC_DEBOUNCE_CYC (`TIDEC_DEBOUNCE_US * `TIDEC_CLK_MHZ)

`endif

// ===== rtl/tidec_core.v
`timescale 1ns/1ns
`default_nettype none
`include "tidec_defines.vh"

module tidec_core #(
  parameter NUM_TERM = 4,
  parameter CNT_W = 16,
  parameter [15:0] DEBOUNCE_CYCLES = `TIDEC_DEBOUNCE_CYC
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Control terminals
  input wire [3:0] term_in,
  input wire hw_enable,
  // Keypad and fieldbus commands
  input wire keypad_start_key,
  input wire keypad_stop_key,
  input wire fieldbus_start,
  input wire fieldbus_stop,
  // Reference inputs
  input wire [11:0] analog_input_one,
  input wire [11:0] analog_input_two,
  input wire [15:0] keypad_speed,
  input wire [15:0] fieldbus_speed,
  input wire [15:0] process_loop_output,
  // Drive commands
  output reg drive_run,
  output reg drive_reverse,
  output reg fast_stop_ramp,
  output reg drive_trip,
  output reg trip_code_sel,
  output reg [15:0] speed_ref,
  output reg [2:0] speed_source,
  output reg [11:0] process_loop_feedback
);

  //------------------------------------------------------------
  // Terminal synchronisers and debounce
  //------------------------------------------------------------
  wire [4:0] raw_in;
  wire [4:0] clean;
  wire [4:0] rise;
  wire [4:0] fall;

  assign raw_in = {hw_enable, term_in};

  genvar g;
  generate
    for (g = 0; g < NUM_TERM + 1; g = g + 1) begin : deb
      reg s1;
      reg s2;
      reg s3;
      reg lvl;
      reg lvl_d;
      reg [CNT_W-1:0] cnt;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          lvl <= 1'b0;
          lvl_d <= 1'b0;
          cnt <= {CNT_W{1'b0}};
        end else begin
          s1 <= raw_in[g];
          s2 <= s1;
          s3 <= s2;
          lvl_d <= lvl;
          if (s2 != s3 || s3 == lvl) begin
            cnt <= {CNT_W{1'b0}};
          end else if (cnt >= DEBOUNCE_CYCLES - 16'h0001) begin
            cnt <= {CNT_W{1'b0}};
            lvl <= s3;
          end else begin
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      assign clean[g] = lvl;
      assign rise[g] = lvl & ~lvl_d;
      assign fall[g] = ~lvl & lvl_d;
    end
  endgenerate

  wire en_lvl;
  wire en_rise;

  assign en_lvl = clean[4];
  assign en_rise = rise[4];

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  reg [31:0] ctrl;
  reg [31:0] func;
  reg [31:0] pre01;
  reg [31:0] pre23;
  reg [15:0] step_ref;

  wire [1:0] mode;
  wire [15:0] preset0;

  assign mode = ctrl[`TIDEC_CTRL_MODE];
  assign preset0 = pre01[15:0];

  wire wr_en;
  wire trip_clr;

  assign wr_en = psel & penable & pready & pwrite;
  assign trip_clr = wr_en && paddr == `TIDEC_ADDR_CTRL &&
                    pwdata[`TIDEC_CTRL_TRIP_CLR];

  //------------------------------------------------------------
  // Terminal function decode
  //------------------------------------------------------------
  reg stop_open;
  reg lvl_mode;
  reg run_lvl;
  reg fsel;
  reg rsel;
  reg rfwd;
  reg rrev;
  reg p_start;
  reg p_fwd;
  reg p_rev;
  reg sp_seen;
  reg sp_all;
  reg sp_rise;
  reg fp_seen;
  reg fp_all;
  reg fp_rise;
  reg nc_ok;
  reg stop_fall;
  reg fast_fall;
  reg trip_fall;
  reg alt_on;
  reg pb0;
  reg pb1;
  reg step_up;
  reg step_dn;
  reg [4:0] fn;
  integer i;

  always @* begin
    stop_open = 1'b0;
    lvl_mode = 1'b0;
    run_lvl = 1'b0;
    fsel = 1'b0;
    rsel = 1'b0;
    rfwd = 1'b0;
    rrev = 1'b0;
    p_start = 1'b0;
    p_fwd = 1'b0;
    p_rev = 1'b0;
    sp_seen = 1'b0;
    sp_all = 1'b1;
    sp_rise = 1'b0;
    fp_seen = 1'b0;
    fp_all = 1'b1;
    fp_rise = 1'b0;
    nc_ok = 1'b1;
    stop_fall = 1'b0;
    fast_fall = 1'b0;
    trip_fall = 1'b0;
    alt_on = 1'b0;
    pb0 = 1'b0;
    pb1 = 1'b0;
    step_up = 1'b0;
    step_dn = 1'b0;
    fn = 5'h00;
    for (i = 0; i < NUM_TERM; i = i + 1) begin
      fn = func[5*i +: 5];
      case (fn)
        `TIDEC_FN_STOP_LVL: begin
          stop_open = stop_open | ~clean[i];
          nc_ok = nc_ok & clean[i];
        end
        `TIDEC_FN_RUN_LVL: begin
          lvl_mode = 1'b1;
          run_lvl = run_lvl | clean[i];
        end
        `TIDEC_FN_FWD_SEL: fsel = fsel | clean[i];
        `TIDEC_FN_REV_SEL: rsel = rsel | clean[i];
        `TIDEC_FN_RUN_FORWARD_LEVEL: begin
          lvl_mode = 1'b1;
          run_lvl = run_lvl | clean[i];
          rfwd = rfwd | clean[i];
        end
        `TIDEC_FN_RUN_REVERSE_LEVEL: begin
          lvl_mode = 1'b1;
          run_lvl = run_lvl | clean[i];
          rrev = rrev | clean[i];
        end
        `TIDEC_FN_START: p_start = p_start | rise[i];
        `TIDEC_FN_START_PAIR: begin
          sp_seen = 1'b1;
          sp_all = sp_all & clean[i];
          sp_rise = sp_rise | rise[i];
        end
        `TIDEC_FN_STOP_NC: begin
          stop_fall = stop_fall | fall[i];
          nc_ok = nc_ok & clean[i];
        end
        `TIDEC_FN_START_FORWARD_PULSE: p_fwd = p_fwd | rise[i];
        `TIDEC_FN_START_REVERSE_PULSE: p_rev = p_rev | rise[i];
        `TIDEC_FN_FAST_PAIR: begin
          fp_seen = 1'b1;
          fp_all = fp_all & clean[i];
          fp_rise = fp_rise | rise[i];
        end
        `TIDEC_FN_FAST_NC: begin
          fast_fall = fast_fall | fall[i];
          nc_ok = nc_ok & clean[i];
        end
        `TIDEC_FN_TRIP_NC: trip_fall = trip_fall | fall[i];
        `TIDEC_FN_ALT_REF: alt_on = alt_on | clean[i];
        `TIDEC_FN_PRE_B0: pb0 = pb0 | clean[i];
        `TIDEC_FN_PRE_B1: pb1 = pb1 | clean[i];
        `TIDEC_FN_STEP_UP: step_up = step_up | rise[i];
        `TIDEC_FN_STEP_DN: step_dn = step_dn | rise[i];
        default: fn = fn;
      endcase
    end
  end

  //------------------------------------------------------------
  // Run, stop and direction decision
  //------------------------------------------------------------
  wire is_term;
  wire fast_req;
  wire term_start;
  wire kpd_start;
  wire bus_start;
  wire start_req;
  wire stop_req;

  assign is_term = mode == `TIDEC_MODE_TERM;
  assign fast_req = (fp_seen & fp_all & fp_rise) | fast_fall;
  assign term_start = is_term & nc_ok &
                      (p_start | p_fwd | p_rev |
                       (sp_seen & sp_all & sp_rise) |
                       (lvl_mode & run_lvl & ~drive_run));
  assign kpd_start = mode == `TIDEC_MODE_KPD & en_lvl &
                     ((en_rise & ctrl[`TIDEC_CTRL_KPD_AUTO]) |
                      keypad_start_key);
  assign bus_start = mode == `TIDEC_MODE_BUS & en_lvl &
                     fieldbus_start;
  assign start_req = term_start | kpd_start | bus_start;
  assign stop_req = stop_open | stop_fall | fast_req |
                    trip_fall | drive_trip |
                    (is_term & lvl_mode & ~run_lvl) |
                    (~is_term & ~en_lvl) |
                    keypad_stop_key | fieldbus_stop;

  reg next_rev;

  always @* begin
    next_rev = drive_reverse;
    if (rsel) begin
      next_rev = 1'b1;
    end else if (fsel) begin
      next_rev = 1'b0;
    end
    if (rrev) begin
      next_rev = 1'b1;
    end else if (rfwd) begin
      next_rev = 1'b0;
    end
    if (is_term & nc_ok & p_rev) begin
      next_rev = 1'b1;
    end else if (is_term & nc_ok & p_fwd) begin
      next_rev = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_run <= 1'b0;
      drive_reverse <= 1'b0;
      fast_stop_ramp <= 1'b0;
      drive_trip <= 1'b0;
      trip_code_sel <= 1'b0;
    end else begin
      drive_reverse <= next_rev;
      if (stop_req) begin
        drive_run <= 1'b0;
      end else if (start_req) begin
        drive_run <= 1'b1;
      end
      if (fast_req) begin
        fast_stop_ramp <= 1'b1;
      end else if (start_req & ~stop_req) begin
        fast_stop_ramp <= 1'b0;
      end
      if (trip_fall) begin
        drive_trip <= 1'b1;
        trip_code_sel <= ctrl[`TIDEC_CTRL_AI2_FMT];
      end else if (trip_clr) begin
        drive_trip <= 1'b0;
      end
    end
  end

  //------------------------------------------------------------
  // Speed reference selection
  //------------------------------------------------------------
  reg [2:0] src;
  reg [15:0] next_ref;
  reg [15:0] pre_sel;
  reg [15:0] grp_sel;
  reg [17:0] sum;

  always @* begin
    src = alt_on ? ctrl[`TIDEC_CTRL_ALT_SRC] : ctrl[`TIDEC_CTRL_BASE_SRC];
    case (ctrl[`TIDEC_CTRL_PRESET])
      2'h0: pre_sel = pre01[15:0];
      2'h1: pre_sel = pre01[31:16];
      2'h2: pre_sel = pre23[15:0];
      default: pre_sel = pre23[31:16];
    endcase
    case ({pb1, pb0})
      2'h0: grp_sel = pre01[15:0];
      2'h1: grp_sel = pre01[31:16];
      2'h2: grp_sel = pre23[15:0];
      default: grp_sel = pre23[31:16];
    endcase
    case (src)
      `TIDEC_SRC_AI1: next_ref = {4'h0, analog_input_one};
      `TIDEC_SRC_AI2: next_ref = {4'h0, analog_input_two};
      `TIDEC_SRC_PRESET: next_ref = pre_sel;
      `TIDEC_SRC_GROUP: next_ref = grp_sel;
      `TIDEC_SRC_KPD: next_ref = keypad_speed;
      `TIDEC_SRC_BUS: next_ref = fieldbus_speed;
      `TIDEC_SRC_LOOP: next_ref = process_loop_output;
      default: next_ref = step_ref;
    endcase
    sum = {2'h0, step_ref};
    if (step_up & ~step_dn) begin
      sum = {2'h0, step_ref} + {2'h0, preset0};
    end else if (step_dn & ~step_up) begin
      sum = {2'h0, step_ref} - {2'h0, preset0};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_ref <= 16'h0000;
      speed_source <= 3'h0;
      process_loop_feedback <= 12'h000;
      step_ref <= 16'h0000;
    end else begin
      speed_ref <= next_ref;
      speed_source <= src;
      process_loop_feedback <= ctrl[`TIDEC_CTRL_FB_SEL] ?
                               analog_input_two :
                               analog_input_one;
      if (sum[17]) begin
        step_ref <= 16'h0000;
      end else if (sum[16]) begin
        step_ref <= 16'hFFFF;
      end else begin
        step_ref <= sum[15:0];
      end
    end
  end

  //------------------------------------------------------------
  // APB slave
  //------------------------------------------------------------
  reg [31:0] rd_mux;
  reg rd_err;

  always @* begin
    rd_err = 1'b0;
    case (paddr)
      `TIDEC_ADDR_CTRL: rd_mux = ctrl;
      `TIDEC_ADDR_FUNC: rd_mux = func;
      `TIDEC_ADDR_PRE01: rd_mux = pre01;
      `TIDEC_ADDR_PRE23: rd_mux = pre23;
      `TIDEC_ADDR_STATUS: rd_mux = {16'h0000, 3'h0, clean,
                                    speed_source, trip_code_sel,
                                    drive_trip, fast_stop_ramp,
                                    drive_reverse, drive_run};
      `TIDEC_ADDR_SPEED: rd_mux = {step_ref, speed_ref};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl <= `TIDEC_CTRL_RESET;
      func <= `TIDEC_FUNC_RESET;
      pre01 <= 32'h0000_0000;
      pre23 <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rd_err;
      if (psel & penable & ~pready & (~pwrite | rd_err)) begin
        prdata <= rd_mux;
      end
      if (wr_en) begin
        case (paddr)
          `TIDEC_ADDR_CTRL: begin
            ctrl <= pwdata & 32'h0000_3FEF;
          end
          `TIDEC_ADDR_FUNC: func <= pwdata & 32'h000F_FFFF;
          `TIDEC_ADDR_PRE01: pre01 <= pwdata;
          `TIDEC_ADDR_PRE23: pre23 <= pwdata;
          default: ctrl <= ctrl;
        endcase
      end
    end
  end

endmodule // tidec_core

`default_nettype wire

// ===== tb/tidec_contacts.sv
`timescale 1ns/1ns
`default_nettype none

module tidec_contacts (
  // Clock
  input wire logic pclk,
  // Commanded contact state
  input wire logic [3:0] want,
  // Terminal wires
  output var logic [3:0] term_in
);
  logic [3:0] last;
  logic [3:0] mask;
  logic [1:0] n;

  initial begin
    last = 4'h0;
    mask = 4'h0;
    n = 2'h0;
    term_in = 4'h0;
  end

  // ----------------------------------------
  // Contacts chatter three cycles, then settle
  // ----------------------------------------
  always @(posedge pclk) begin
    if (want != last) begin
      last <= want;
      mask <= want ^ last;
      n <= 2'h3;
      term_in <= term_in ^ (want ^ last);
    end else if (n != 2'h0) begin
      n <= n - 2'h1;
      term_in <= (n == 2'h1) ? last : (term_in ^ mask);
    end
  end
endmodule // tidec_contacts

`default_nettype wire

// ===== tb/tidec_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "tidec_defines.vh"

module tidec_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // References
  input wire logic [15:0] keypad_speed,
  input wire logic [15:0] fieldbus_speed,
  // Commands
  input wire logic drive_run,
  input wire logic fast_stop_ramp,
  input wire logic drive_trip,
  input wire logic [15:0] speed_ref,
  input wire logic [2:0] speed_source
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ready_in_access: assert property (
    pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside a held access");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero_data: assert property (
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("bad error response");
  a_trip_blocks_run: assert property (drive_trip |-> !drive_run)
    else $error("running while tripped");
  a_trip_clear_write: assert property (
    $fell(drive_trip) |-> $past(pready && pwrite && paddr ==
      `TIDEC_ADDR_CTRL && pwdata[`TIDEC_CTRL_TRIP_CLR]))
    else $error("trip cleared without a clear write");
  a_fast_stops_run: assert property (
    $rose(fast_stop_ramp) |-> !drive_run)
    else $error("fast stop flagged while running");
  a_keypad_ref: assert property (
    speed_source == `TIDEC_SRC_KPD && $past(speed_source) ==
    `TIDEC_SRC_KPD && $stable(keypad_speed) |-> speed_ref == keypad_speed)
    else $error("keypad reference not passed");
  a_bus_ref: assert property (
    (speed_source == `TIDEC_SRC_BUS) [*2] ##0 $stable(fieldbus_speed)
    |-> speed_ref == fieldbus_speed)
    else $error("fieldbus reference not passed");

  c_run: cover property ($rose(drive_run));
  c_trip: cover property ($rose(drive_trip));
  c_err: cover property (pslverr);
endmodule // tidec_chk

bind tidec_core tidec_chk u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .keypad_speed, .fieldbus_speed, .drive_run,
  .fast_stop_ramp, .drive_trip, .speed_ref, .speed_source
);

`default_nettype wire

// ===== tb/tidec_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "tidec_defines.vh"

module terminal_input_command_decoder_tb_top;
  typedef struct packed {
    logic [3:0] t;
    logic [2:0] o;
  } tidec_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, got;
  logic [3:0] want, term_in, keys;
  logic hw_enable, drive_run, drive_reverse, fast_stop_ramp;
  logic drive_trip, trip_code_sel;
  logic [15:0] speed_ref, kspd;
  logic [2:0] speed_source;
  logic [11:0] fb, ai2;
  int fails, num_checks;
  tidec_row_t rows [5];
  logic [18:0] srcs [5];

  tidec_core #(.DEBOUNCE_CYCLES(16'h0004)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .term_in, .hw_enable,
    .keypad_start_key(keys[0]), .keypad_stop_key(keys[1]),
    .fieldbus_start(keys[2]), .fieldbus_stop(keys[3]),
    .analog_input_one(12'h123), .analog_input_two(ai2),
    .keypad_speed(kspd), .fieldbus_speed(16'h0DEF),
    .process_loop_output(16'h0777), .drive_run, .drive_reverse,
    .fast_stop_ramp, .drive_trip, .trip_code_sel, .speed_ref,
    .speed_source, .process_loop_feedback(fb)
  );
  tidec_contacts u_contacts (.pclk, .want, .term_in);

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] g,
                     input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      fails++;
      tally_and_finish();
    end
  endtask

  // Contacts, enable and one key pulse, then settle
  task automatic step(input logic [3:0] v, input logic e,
                      input logic [3:0] m);
    @(posedge pclk);
    want <= v;
    hw_enable <= e;
    keys <= m;
    @(posedge pclk);
    keys <= 4'h0;
    repeat (20) @(posedge pclk);
    @(negedge pclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, hw_enable} = 5'h00;
    {paddr, pwdata, want, keys} = 48'h0;
    ai2 = 12'h456;
    kspd = 16'h0ABC;
    rows = '{'{4'hC, 3'h0}, '{4'hD, 3'h4}, '{4'hE, 3'h6},
             '{4'h9, 3'h0}, '{4'h5, 3'h1}};
    srcs = '{19'h4_0ABC, 19'h5_0DEF, 19'h2_0321, 19'h6_0777, 19'h1_0456};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("reset outputs", 32'({drive_run, drive_trip}), 32'h0);
    apb(1'b0, `TIDEC_ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, `TIDEC_CTRL_RESET);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", {er, rd[30:0]}, 32'h8000_0000);
    $display("done reset");
    apb(1'b1, `TIDEC_ADDR_FUNC, 32'h0007_04C5);
    foreach (rows[i]) begin
      step(rows[i].t, 1'b1, 4'h0);
      got = 32'({drive_run, drive_reverse, drive_trip});
      chk("run_reverse_level trip", got, 32'(rows[i].o));
    end
    $display("done levels");
    step(4'hC, 1'b1, 4'h0);
    apb(1'b1, `TIDEC_ADDR_CTRL, 32'h0000_0018);
    step(4'h4, 1'b1, 4'h0);
    chk("trip code", 32'({drive_trip, trip_code_sel}), 32'h3);
    step(4'hC, 1'b1, 4'h0);
    apb(1'b1, `TIDEC_ADDR_CTRL, 32'h0000_0010);
    @(negedge pclk);
    chk("trip clear", 32'(drive_trip), 32'h0);
    $display("done trip");
    apb(1'b1, `TIDEC_ADDR_FUNC, 32'h0005_B527);
    step(4'h6, 1'b1, 4'h0);
    step(4'h7, 1'b1, 4'h0);
    step(4'h6, 1'b1, 4'h0);
    chk("start", 32'({drive_run, drive_reverse}), 32'h2);
    step(4'h4, 1'b1, 4'h0);
    step(4'h6, 1'b1, 4'h0);
    chk("nc stop", 32'(drive_run), 32'h0);
    step(4'hE, 1'b1, 4'h0);
    step(4'h6, 1'b1, 4'h0);
    chk("start_reverse_pulse", 32'({drive_run, drive_reverse}), 32'h3);
    step(4'h2, 1'b1, 4'h0);
    chk("fast stop", 32'({drive_run, fast_stop_ramp}), 32'h1);
    step(4'h3, 1'b1, 4'h0);
    chk("start blocked", 32'(drive_run), 32'h0);
    $display("done pulses");
    apb(1'b1, `TIDEC_ADDR_FUNC, 32'h0);
    apb(1'b1, `TIDEC_ADDR_CTRL, 32'h0000_0001);
    step(4'h0, 1'b1, 4'h0);
    chk("kpd wait", 32'(drive_run), 32'h0);
    step(4'h0, 1'b1, 4'h1);
    chk("kpd key", 32'(drive_run), 32'h1);
    step(4'h0, 1'b0, 4'h0);
    apb(1'b1, `TIDEC_ADDR_CTRL, 32'h0000_0005);
    step(4'h0, 1'b1, 4'h0);
    chk("kpd auto", 32'(drive_run), 32'h1);
    $display("done keypad");
    apb(1'b1, `TIDEC_ADDR_CTRL, 32'h0000_0002);
    step(4'h0, 1'b0, 4'h0);
    step(4'h0, 1'b0, 4'h4);
    chk("bus no enable", 32'(drive_run), 32'h0);
    step(4'h0, 1'b1, 4'h0); // enable ahead of start
    step(4'h0, 1'b1, 4'h4);
    chk("bus start", 32'(drive_run), 32'h1);
    step(4'h0, 1'b1, 4'h8);
    chk("bus stop", 32'(drive_run), 32'h0);
    $display("done fieldbus");
    apb(1'b1, `TIDEC_ADDR_PRE01, 32'h0000_0321);
    foreach (srcs[i]) begin
      apb(1'b1, `TIDEC_ADDR_CTRL, 32'(srcs[i][18:16]) << 5);
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      got = 32'(srcs[i][15:0]);
      chk("speed ref", 32'(speed_ref), got);
    end
    apb(1'b1, `TIDEC_ADDR_FUNC, 32'h0000_4612);
    apb(1'b1, `TIDEC_ADDR_PRE23, 32'h0BBB_0AAA);
    apb(1'b1, `TIDEC_ADDR_CTRL, 32'h0000_0060);
    step(4'h6, 1'b1, 4'h0);
    chk("preset group", 32'(speed_ref), 32'h0000_0BBB);
    apb(1'b1, `TIDEC_ADDR_CTRL, 32'h0000_00E0);
    step(4'h7, 1'b1, 4'h0);
    step(4'h6, 1'b1, 4'h0);
    step(4'h7, 1'b1, 4'h0);
    chk("step up", 32'(speed_ref), 32'h0000_0642);
    apb(1'b1, `TIDEC_ADDR_CTRL, 32'h0000_2000);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("loop feedback", 32'(fb), 32'h0000_0456);
    $display("done sources");
    tally_and_finish();
  end
endmodule // terminal_input_command_decoder_tb_top

`default_nettype wire
